// ===== hw/eeprom_consts.svh
// timing counts, field sizes and opcodes of the three-wire eeprom link
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH
`define CORE_PERIOD_NS 100
`define CORE_CLK_MHZ 10
`define MEM_BYTES 128
`define ADDR_BITS_X8 5'h07
`define ADDR_BITS_X16 5'h06
`define DATA_BITS_X8 5'h08
`define DATA_BITS_X16 5'h10
`define ERASED_BYTE 8'hff
`define OPC_READ 2'h2
`define OPC_WRITE 2'h1
`define OPC_ERASE 2'h3
`define OPC_EXT 2'h0
`define EXT_ENABLE 2'h3
`define EXT_ERASE_ALL 2'h2
`define EXT_WRITE_ALL 2'h1
`define EXT_DISABLE 2'h0
`define PROG_CYCLE_TIME_US 5000
`define PROG_CYCLES (`PROG_CYCLE_TIME_US * `CORE_CLK_MHZ)
`define SELECT_LOW_TIME_NS 250
`define SELECT_LOW_CYCLES ((`SELECT_LOW_TIME_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define LINK_HALF_CYCLES 3'h4
`define STATUS_SETTLE_CYCLES 4'h8
`define FIFO_DEPTH 16
`endif

// ===== hw/eeprom_pkg.sv
// types shared by both ends of the eeprom link
package eeprom_pkg;
    typedef enum logic [4:0] {
        DEV_IDLE = 5'h01, DEV_CMD = 5'h02, DEV_DATA = 5'h04, DEV_READ = 5'h08, DEV_DONE = 5'h10
    } devState_t;
    typedef enum logic [4:0] {
        HST_IDLE = 5'h01, HST_SHIFT = 5'h02, HST_READ = 5'h04, HST_GAP = 5'h08, HST_POLL = 5'h10
    } hostState_t;
    typedef enum logic [2:0] {
        CMD_READ = 3'h0, CMD_WRITE = 3'h1, CMD_ERASE = 3'h2, CMD_PROG_ENABLE = 3'h3,
        CMD_PROG_DISABLE = 3'h4, CMD_ERASE_ALL = 3'h5, CMD_WRITE_ALL = 3'h6
    } hostCmd_t;
endpackage

// ===== hw/eeprom_link_if.sv
// three-wire link between the host controller and the eeprom
`timescale 1ns/1ps
interface eeprom_link_if;
    logic selectLine;
    logic shiftClock;
    logic serialIn;
    logic serialOut;
    logic serialOutEn;
    logic dataLine;
    // weak pull-up when the device leaves its output floating
    assign dataLine = serialOutEn ? serialOut : 1'b1;
    modport device (input selectLine, input shiftClock, input serialIn, output serialOut, output serialOutEn);
    modport host (output selectLine, output shiftClock, output serialIn, input dataLine);
endinterface

// ===== hw/cmd_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module cmd_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    input wire logic core_clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic inValid, // writer offers a word
    output logic inReady, // room for a word
    input wire logic [WIDTH-1:0] inData, // word to store
    output logic outValid, // a word is waiting
    input wire logic outReady, // reader takes the word
    output logic [WIDTH-1:0] outData // oldest word
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0] wrPtr_q;
    logic [PW:0] rdPtr_q;
    logic push;
    logic pop;
    // extra pointer bit tells full from empty
    assign inReady = (wrPtr_q[PW] == rdPtr_q[PW]) || (wrPtr_q[PW-1:0] != rdPtr_q[PW-1:0]);
    assign outValid = wrPtr_q != rdPtr_q;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem_q[rdPtr_q[PW-1:0]];
    ////////////////////////////////////////////////////////////////
    // storage, no reset needed on the data
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wrPtr_q[PW-1:0]] <= inData;
        end
    end
    // pointers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule

// ===== hw/eeprom_host.sv
// host controller end: queues commands and drives the three-wire link
`timescale 1ns/1ps
`include "eeprom_consts.svh"
module eeprom_host (
    input wire logic core_clk, // 10 MHz system clock
    input wire logic rst_b, // async reset, active low
    eeprom_link_if.host link, // three-wire link
    input wire logic organisation_select, // 1 = x16 words, 0 = x8 bytes
    input wire logic cmdValid, // command offered
    output logic cmdReady, // queue has room
    input wire eeprom_pkg::hostCmd_t cmdCode, // which instruction
    input wire logic [6:0] cmdAddr, // location, x16 uses low six bits
    input wire logic [15:0] cmdData, // data, x8 uses low byte
    output logic rspValid, // one-cycle pulse: command finished
    output logic [15:0] rspData // read data, zero otherwise
);
    eeprom_pkg::hostState_t state_q;
    logic qValid;
    logic qReady;
    logic [25:0] qData;
    eeprom_pkg::hostCmd_t qCode;
    logic [1:0] opc;
    logic [6:0] fAddr;
    logic hasData;
    logic [4:0] fLen;
    logic [25:0] frame;
    logic [25:0] txSh_q;
    logic [4:0] left_q;
    logic [4:0] rxCnt_q;
    logic [15:0] rx_q;
    logic [2:0] half_q;
    logic [3:0] wait_q;
    logic sk_q;
    logic sel_q;
    logic curRead_q;
    logic pollPending_q;
    logic [1:0] doS_q;
    logic tick;
    logic [4:0] dw;
    ////////////////////////////////////////////////////////////////
    // command queue lets the user run ahead of the slow link
    cmd_fifo #(.WIDTH(26), .DEPTH(`FIFO_DEPTH)) cmd_fifo_inst (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .inValid(cmdValid),
        .inReady(cmdReady),
        .inData({cmdCode, cmdAddr, cmdData}),
        .outValid(qValid),
        .outReady(qReady),
        .outData(qData)
    );
    assign qReady = state_q == eeprom_pkg::HST_IDLE;
    assign qCode = eeprom_pkg::hostCmd_t'(qData[25:23]);
    assign dw = organisation_select ? `DATA_BITS_X16 : `DATA_BITS_X8;
    ////////////////////////////////////////////////////////////////
    // frame builder: start bit, opcode, address, optional data
    always_comb begin
        opc = `OPC_EXT;
        fAddr = qData[22:16];
        hasData = 1'b0;
        case (qCode)
            eeprom_pkg::CMD_READ: opc = `OPC_READ;
            eeprom_pkg::CMD_WRITE: begin
                opc = `OPC_WRITE;
                hasData = 1'b1;
            end
            eeprom_pkg::CMD_ERASE: opc = `OPC_ERASE;
            eeprom_pkg::CMD_PROG_ENABLE: fAddr = {`EXT_ENABLE, 5'h00};
            eeprom_pkg::CMD_ERASE_ALL: fAddr = {`EXT_ERASE_ALL, 5'h00};
            eeprom_pkg::CMD_WRITE_ALL: begin
                fAddr = {`EXT_WRITE_ALL, 5'h00};
                hasData = 1'b1;
            end
            default: fAddr = {`EXT_DISABLE, 5'h00};
        endcase
        // x16 selector sits one bit lower; don't-care bits still go out as zeros
        if (organisation_select && opc == `OPC_EXT) begin
            fAddr = {1'b0, fAddr[6:5], 4'h0};
        end
        if (organisation_select) begin
            frame = {1'b1, opc, fAddr[5:0], qData[15:0], 1'b0};
            fLen = 5'h09 + (hasData ? `DATA_BITS_X16 : 5'h00);
        end else begin
            frame = {1'b1, opc, fAddr, qData[7:0], 8'h00};
            fLen = 5'h0a + (hasData ? `DATA_BITS_X8 : 5'h00);
        end
    end
    ////////////////////////////////////////////////////////////////
    // shift clock divider, runs only inside a frame
    assign tick = half_q == `LINK_HALF_CYCLES - 3'h1;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            half_q <= 3'h0;
        end else if (tick || !(state_q == eeprom_pkg::HST_SHIFT || state_q == eeprom_pkg::HST_READ)) begin
            half_q <= 3'h0;
        end else begin
            half_q <= half_q + 3'h1;
        end
    end
    // returned data line, pin domain
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            doS_q <= 2'h0;
        end else begin
            doS_q <= {doS_q[0], link.dataLine};
        end
    end
    ////////////////////////////////////////////////////////////////
    // link sequencer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= eeprom_pkg::HST_IDLE;
            sel_q <= 1'b0;
            sk_q <= 1'b0;
            txSh_q <= 26'h0;
            left_q <= 5'h0;
            rxCnt_q <= 5'h0;
            rx_q <= 16'h0;
            wait_q <= 4'h0;
            curRead_q <= 1'b0;
            pollPending_q <= 1'b0;
            rspValid <= 1'b0;
            rspData <= 16'h0;
        end else begin
            rspValid <= 1'b0;
            case (state_q)
                eeprom_pkg::HST_IDLE: begin
                    if (qValid) begin
                        state_q <= eeprom_pkg::HST_SHIFT;
                        sel_q <= 1'b1;
                        txSh_q <= frame;
                        left_q <= fLen;
                        rxCnt_q <= 5'h0;
                        curRead_q <= qCode == eeprom_pkg::CMD_READ;
                        // enable/disable never start a programming cycle
                        pollPending_q <= !(qCode == eeprom_pkg::CMD_READ || qCode == eeprom_pkg::CMD_PROG_ENABLE
                            || qCode == eeprom_pkg::CMD_PROG_DISABLE);
                    end
                end
                eeprom_pkg::HST_SHIFT: begin
                    if (tick && !sk_q) begin
                        sk_q <= 1'b1;
                        left_q <= left_q - 5'h1;
                    end else if (tick) begin
                        sk_q <= 1'b0;
                        txSh_q <= {txSh_q[24:0], 1'b0};
                        if (left_q == 5'h0 && curRead_q) begin
                            state_q <= eeprom_pkg::HST_READ;
                        end else if (left_q == 5'h0) begin
                            sel_q <= 1'b0;
                            wait_q <= 4'h0;
                            state_q <= eeprom_pkg::HST_GAP;
                        end
                    end
                end
                eeprom_pkg::HST_READ: begin
                    // first rise after the address skips the dummy zero
                    if (tick && !sk_q) begin
                        sk_q <= 1'b1;
                        rxCnt_q <= rxCnt_q + 5'h1;
                        if (rxCnt_q != 5'h0) begin
                            rx_q <= {rx_q[14:0], doS_q[1]};
                        end
                    end else if (tick && rxCnt_q == dw + 5'h1) begin
                        sk_q <= 1'b0;
                        sel_q <= 1'b0;
                        rspData <= organisation_select ? rx_q : {8'h00, rx_q[7:0]};
                        wait_q <= 4'h0;
                        state_q <= eeprom_pkg::HST_GAP;
                    end else if (tick) begin
                        sk_q <= 1'b0;
                    end
                end
                eeprom_pkg::HST_GAP: begin
                    // select held low at least the minimum time between frames
                    wait_q <= wait_q + 4'h1;
                    if (wait_q == 4'(`SELECT_LOW_CYCLES) && pollPending_q) begin
                        sel_q <= 1'b1;
                        wait_q <= 4'h0;
                        state_q <= eeprom_pkg::HST_POLL;
                    end else if (wait_q == 4'(`SELECT_LOW_CYCLES)) begin
                        rspValid <= 1'b1;
                        if (!curRead_q) begin
                            rspData <= 16'h0;
                        end
                        state_q <= eeprom_pkg::HST_IDLE;
                    end
                end
                eeprom_pkg::HST_POLL: begin
                    // wait out both synchronisers before trusting the status
                    if (wait_q != `STATUS_SETTLE_CYCLES) begin
                        wait_q <= wait_q + 4'h1;
                    end else if (doS_q[1]) begin
                        sel_q <= 1'b0;
                        pollPending_q <= 1'b0;
                        wait_q <= 4'h0;
                        state_q <= eeprom_pkg::HST_GAP;
                    end
                end
                default: state_q <= eeprom_pkg::HST_IDLE;
            endcase
        end
    end
    // programming commands only work after an enable issued by the user
    assign link.selectLine = sel_q;
    assign link.shiftClock = sk_q;
    assign link.serialIn = txSh_q[25];
endmodule

// ===== hw/eeprom_device.sv
// eeprom end: decodes instructions on the three-wire link and holds the array
//
// Behaviour
// - select rise, start bit, opcode, address frame
// - seven instructions decoded
// - read data changes on shift clock rise
// - read sends dummy zero, then data word
// - reset leaves programming disabled
// - host enables before any erase or write
// - enable holds until disable or reset
// - erase sets word to ones, starts at decode
// - select low gap, then status on rise
// - status zero while busy, one when ready
// - write cycle starts after last data bit
// - no status if cycle already finished
// - erase all sets array to ones
// - write all fills array with one word
// - disable blocks erase and write
// - read works whether enabled or not
// - opcode and selector bit encodings
// - host clocks all don't-care address bits
`timescale 1ns/1ps
`include "eeprom_consts.svh"
module eeprom_device #(
    parameter int PROG_CYCLES = `PROG_CYCLES
) (
    input wire logic core_clk, // 10 MHz system clock
    input wire logic rst_b, // async reset, active low
    eeprom_link_if.device link, // three-wire link
    input wire logic organisation_select, // 1 = x16 words, 0 = x8 bytes
    output logic progEnabled, // programming enabled
    output logic progBusy // self-timed cycle running
);
    eeprom_pkg::devState_t state_q;
    logic [1:0] selS_q;
    logic [1:0] skS_q;
    logic [1:0] siS_q;
    logic [1:0] orgS_q;
    logic skPrev_q;
    logic selPrev_q;
    logic sel;
    logic si;
    logic skRise;
    logic selRise;
    logic wordMode;
    logic [4:0] aw;
    logic [4:0] dw;
    logic [4:0] cnt_q;
    logic [7:0] cmdSh_q;
    logic [15:0] dataSh_q;
    logic [15:0] rdSh_q;
    logic rdOut_q;
    logic rdOe_q;
    logic [6:0] cmdAddr_q;
    logic cmdAll_q;
    logic [8:0] full;
    logic [1:0] opc;
    logic [6:0] addr;
    logic [1:0] sub;
    logic lastCmd;
    logic lastData;
    logic startProg;
    logic [15:0] rdWord;
    logic [15:0] newData;
    logic [7:0] mem_q [`MEM_BYTES];
    logic [19:0] timer_q;
    logic [7:0] ptr_q;
    logic [6:0] progAddr_q;
    logic progAll_q;
    logic progErase_q;
    logic [15:0] progData_q;
    logic sweepHit;
    logic statusShow_q;
    ////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            selS_q <= 2'h0;
            skS_q <= 2'h0;
            siS_q <= 2'h0;
            orgS_q <= 2'h0;
            skPrev_q <= 1'b0;
            selPrev_q <= 1'b0;
        end else begin
            selS_q <= {selS_q[0], link.selectLine};
            skS_q <= {skS_q[0], link.shiftClock};
            siS_q <= {siS_q[0], link.serialIn};
            orgS_q <= {orgS_q[0], organisation_select};
            skPrev_q <= skS_q[1];
            selPrev_q <= selS_q[1];
        end
    end
    assign sel = selS_q[1];
    assign si = siS_q[1];
    assign skRise = skS_q[1] && !skPrev_q;
    assign selRise = sel && !selPrev_q;
    assign wordMode = orgS_q[1];
    assign aw = wordMode ? `ADDR_BITS_X16 : `ADDR_BITS_X8;
    assign dw = wordMode ? `DATA_BITS_X16 : `DATA_BITS_X8;
    ////////////////////////////////////////////////////////////////
    // instruction decode on the final address bit
    assign full = {cmdSh_q, si};
    assign opc = wordMode ? full[7:6] : full[8:7];
    assign addr = wordMode ? {1'b0, full[5:0]} : full[6:0];
    assign sub = wordMode ? addr[5:4] : addr[6:5];
    assign lastCmd = state_q == eeprom_pkg::DEV_CMD && sel && skRise && cnt_q == aw + 5'h1;
    assign lastData = state_q == eeprom_pkg::DEV_DATA && sel && skRise && cnt_q == dw - 5'h1;
    assign newData = {dataSh_q[14:0], si};
    // erase runs at decode, writes only after their last data bit
    assign startProg = progEnabled && (lastData || (lastCmd && (opc == `OPC_ERASE
        || (opc == `OPC_EXT && sub == `EXT_ERASE_ALL))));
    assign rdWord = wordMode ? {mem_q[{addr[5:0], 1'b1}], mem_q[{addr[5:0], 1'b0}]} : {mem_q[addr], 8'h00};
    ////////////////////////////////////////////////////////////////
    // frame sequencer; a new select rise always restarts framing
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= eeprom_pkg::DEV_IDLE;
            cnt_q <= 5'h0;
            cmdSh_q <= 8'h00;
            dataSh_q <= 16'h0;
            rdSh_q <= 16'h0;
            rdOut_q <= 1'b0;
            rdOe_q <= 1'b0;
            cmdAddr_q <= 7'h00;
            cmdAll_q <= 1'b0;
        end else if (!sel || selRise) begin
            state_q <= eeprom_pkg::DEV_IDLE;
            rdOe_q <= 1'b0;
            cnt_q <= 5'h0;
        end else if (skRise) begin
            case (state_q)
                eeprom_pkg::DEV_IDLE: begin
                    // leading zeros ignored; nothing accepted while busy
                    if (si && !progBusy) begin
                        state_q <= eeprom_pkg::DEV_CMD;
                        cnt_q <= 5'h0;
                    end
                end
                eeprom_pkg::DEV_CMD: begin
                    cmdSh_q <= full[7:0];
                    cnt_q <= cnt_q + 5'h1;
                    if (lastCmd) begin
                        cnt_q <= 5'h0;
                        cmdAddr_q <= addr;
                        cmdAll_q <= opc == `OPC_EXT;
                        if (opc == `OPC_READ) begin
                            rdSh_q <= rdWord;
                            rdOut_q <= 1'b0;
                            rdOe_q <= 1'b1;
                            state_q <= eeprom_pkg::DEV_READ;
                        end else if (opc == `OPC_WRITE || (opc == `OPC_EXT && sub == `EXT_WRITE_ALL)) begin
                            state_q <= eeprom_pkg::DEV_DATA;
                        end else begin
                            state_q <= eeprom_pkg::DEV_DONE;
                        end
                    end
                end
                eeprom_pkg::DEV_DATA: begin
                    dataSh_q <= newData;
                    cnt_q <= cnt_q + 5'h1;
                    if (lastData) begin
                        state_q <= eeprom_pkg::DEV_DONE;
                    end
                end
                eeprom_pkg::DEV_READ: begin
                    if (cnt_q == dw) begin
                        rdOe_q <= 1'b0;
                        state_q <= eeprom_pkg::DEV_DONE;
                    end else begin
                        rdOut_q <= rdSh_q[15];
                        rdSh_q <= {rdSh_q[14:0], 1'b0};
                        cnt_q <= cnt_q + 5'h1;
                    end
                end
                eeprom_pkg::DEV_DONE: state_q <= eeprom_pkg::DEV_DONE;
                default: state_q <= eeprom_pkg::DEV_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    // programming enable latch, cleared by reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            progEnabled <= 1'b0;
        end else if (lastCmd && opc == `OPC_EXT && sub == `EXT_ENABLE) begin
            progEnabled <= 1'b1;
        end else if (lastCmd && opc == `OPC_EXT && sub == `EXT_DISABLE) begin
            progEnabled <= 1'b0;
        end
    end
    // self-timed cycle; the sweep updates bytes early, ready only at the end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            progBusy <= 1'b0;
            timer_q <= 20'h0;
            ptr_q <= 8'h00;
            progAddr_q <= 7'h00;
            progAll_q <= 1'b0;
            progErase_q <= 1'b0;
            progData_q <= 16'h0;
        end else if (startProg) begin
            progBusy <= 1'b1;
            timer_q <= 20'(PROG_CYCLES - 1);
            ptr_q <= 8'h00;
            progAddr_q <= lastData ? cmdAddr_q : addr;
            progAll_q <= lastData ? cmdAll_q : opc == `OPC_EXT;
            progErase_q <= !lastData;
            progData_q <= newData;
        end else if (progBusy) begin
            if (!ptr_q[7]) begin
                ptr_q <= ptr_q + 8'h01;
            end
            if (timer_q == 20'h0) begin
                progBusy <= 1'b0;
            end else begin
                timer_q <= timer_q - 20'h1;
            end
        end
    end
    // one byte per clock; the whole array takes 128 cycles
    assign sweepHit = progBusy && !ptr_q[7] && (progAll_q
        || (wordMode ? ptr_q[6:1] == progAddr_q[5:0] : ptr_q[6:0] == progAddr_q));
    always_ff @(posedge core_clk) begin
        if (sweepHit && progErase_q) begin
            mem_q[ptr_q[6:0]] <= `ERASED_BYTE;
        end else if (sweepHit) begin
            mem_q[ptr_q[6:0]] <= (wordMode && ptr_q[0]) ? progData_q[15:8] : progData_q[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    // status shown only for a select rise that finds the cycle running
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            statusShow_q <= 1'b0;
        end else if (selRise) begin
            statusShow_q <= progBusy;
        end else if (!sel || (state_q == eeprom_pkg::DEV_IDLE && skRise && si && !progBusy)) begin
            statusShow_q <= 1'b0;
        end
    end
    assign link.serialOut = statusShow_q ? !progBusy : rdOut_q;
    assign link.serialOutEn = sel && (statusShow_q || rdOe_q);
endmodule

// ===== dv/eeprom_link_chk.sv
// assertions on the three-wire eeprom link
`timescale 1ns/1ps
module eeprom_link_chk #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic core_clk, // clock
    input wire logic rst_b, // reset, low
    input wire logic selectLine, // select
    input wire logic shiftClock, // link clock
    input wire logic serialOut, // device data
    input wire logic serialOutEn, // device drives
    input wire logic progEnabled, // enabled
    input wire logic progBusy // busy
);
    // slack on the busy span absorbs the sync stages
    localparam int BUSY_MIN = PROG_CYCLES - 4;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////
    // framing, select gap and floating output
    chk_clock_low_start: assert property ($rose(selectLine) |-> !shiftClock)
        else $error("clock high at select rise");
    chk_select_gap: assert property ($fell(selectLine) |-> (!selectLine)[*3])
        else $error("select low too short");
    chk_output_floats: assert property ((!selectLine)[*5] |-> !serialOutEn)
        else $error("output driven while unselected");
    chk_lead_zero: assert property ($rose(serialOutEn) |-> !serialOut)
        else $error("first driven bit not zero");
    ////////////////////////////////////////////////////////////
    // self-timed cycle and status
    chk_busy_shows_zero: assert property (serialOutEn && progBusy |-> !serialOut)
        else $error("status high while busy");
    chk_busy_span: assert property ($rose(progBusy) |-> ##BUSY_MIN progBusy ##[1:8] !progBusy)
        else $error("busy span wrong");
    chk_busy_needs_enable: assert property ($rose(progBusy) |-> progEnabled)
        else $error("programming while disabled");
    chk_enable_stable: assert property (progBusy |=> $stable(progEnabled))
        else $error("enable changed while busy");
    chk_no_late_status: assert property ($rose(selectLine) && !progBusy |-> (!serialOutEn)[*8])
        else $error("status shown after cycle end");
endmodule

// ===== dv/test_three_wire_eeprom_command_port.sv
// self-checking bench: host and eeprom joined by the link
`timescale 1ns/1ps
module test_three_wire_eeprom_command_port;
    localparam int PROG = 200;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wideMode = 1'b0;
    logic cmdValid = 1'b0;
    logic cmdReady, rspValid, progEnabled, progBusy;
    logic seenFull = 1'b0;
    eeprom_pkg::hostCmd_t cmdCode = eeprom_pkg::CMD_READ;
    logic [6:0] cmdAddr = 7'h0;
    logic [15:0] cmdData = 16'h0;
    logic [15:0] rspData;
    int fail_count = 0;
    int checks_done = 0;
    eeprom_link_if link();
    eeprom_host eeprom_host_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link), .organisation_select(wideMode),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .rspValid(rspValid), .rspData(rspData));
    eeprom_device #(.PROG_CYCLES(PROG)) eeprom_device_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link),
        .organisation_select(wideMode), .progEnabled(progEnabled), .progBusy(progBusy));
    eeprom_link_chk #(.PROG_CYCLES(PROG)) eeprom_link_chk_inst (.core_clk(core_clk), .rst_b(rst_b),
        .selectLine(link.selectLine), .shiftClock(link.shiftClock), .serialOut(link.serialOut),
        .serialOutEn(link.serialOutEn), .progEnabled(progEnabled), .progBusy(progBusy));
    initial forever #50 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////
    // compare, command and response tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // offer one command and hold it until the queue takes it
    task automatic push(input eeprom_pkg::hostCmd_t c, input logic [6:0] a, input logic [15:0] d);
        @(posedge core_clk);
        cmdCode <= c;
        cmdAddr <= a;
        cmdData <= d;
        cmdValid <= 1'b1;
        @(posedge core_clk);
        while (cmdReady !== 1'b1) begin
            seenFull = 1'b1;
            @(posedge core_clk);
        end
        cmdValid <= 1'b0;
    endtask
    // the pulse lasts one cycle, so look at every falling edge
    task automatic rsp(input logic [15:0] e);
        int n;
        @(negedge core_clk);
        for (n = 0; n < 5000 && rspValid !== 1'b1; n++) @(negedge core_clk);
        check("rspValid", {15'h0, rspValid}, 16'h0001);
        check("rspData", rspData, e);
    endtask
    task automatic op(input eeprom_pkg::hostCmd_t c, input logic [6:0] a, input logic [15:0] d, input logic [15:0] e);
        push(c, a, d);
        rsp(e);
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        check("progEnabled", {15'h0, progEnabled}, 16'h0);
        op(eeprom_pkg::CMD_PROG_ENABLE, 7'h0, 16'h0, 16'h0);
        op(eeprom_pkg::CMD_ERASE_ALL, 7'h0, 16'h0, 16'h0);
        op(eeprom_pkg::CMD_PROG_DISABLE, 7'h0, 16'h0, 16'h0);
        op(eeprom_pkg::CMD_WRITE, 7'h03, 16'h00a5, 16'h0);
        op(eeprom_pkg::CMD_READ, 7'h03, 16'h0, 16'h00ff);
        op(eeprom_pkg::CMD_PROG_ENABLE, 7'h0, 16'h0, 16'h0);
        op(eeprom_pkg::CMD_WRITE, 7'h03, 16'h00a5, 16'h0);
        op(eeprom_pkg::CMD_READ, 7'h03, 16'h0, 16'h00a5);
        op(eeprom_pkg::CMD_WRITE_ALL, 7'h0, 16'h003c, 16'h0);
        op(eeprom_pkg::CMD_ERASE, 7'h7f, 16'h0, 16'h0);
        op(eeprom_pkg::CMD_READ, 7'h7f, 16'h0, 16'h00ff);
        op(eeprom_pkg::CMD_READ, 7'h03, 16'h0, 16'h003c);
        $display("test byte mode done");
        @(posedge core_clk);
        wideMode <= 1'b1;
        op(eeprom_pkg::CMD_READ, 7'h01, 16'h0, 16'h3c3c);
        op(eeprom_pkg::CMD_WRITE, 7'h02, 16'h5aa5, 16'h0);
        op(eeprom_pkg::CMD_READ, 7'h02, 16'h0, 16'h5aa5);
        $display("test word mode done");
        // flood the queue until it refuses while draining responses
        fork
            repeat (18) push(eeprom_pkg::CMD_READ, 7'h01, 16'h0);
            repeat (18) rsp(16'h3c3c);
        join
        check("seenFull", {15'h0, seenFull}, 16'h0001);
        $display("test queue done");
        complete_run();
    end
    // hang guard, far beyond the expected run length
    initial begin
        #(100 * 40000);
        fail_count++;
        complete_run();
    end
endmodule
